/* inc/irqoc_pkg.sv */
// Purpose: Shared constants of the interrupt output configuration block.
// Assumes: A 100 MHz system clock and a 32-bit register bus.
// Notes:   Offsets are byte addresses on the register bus.
package irqoc_pkg;
   localparam int             ADDR_W        = 12;
   localparam logic [11:0]    CFG_OFFSET    = 12'h054;
   localparam int             INTERVAL_LSB  = 24;
   localparam int             RESTART_BIT   = 14;
   localparam int             ACTIVE_BIT    = 13;
   localparam int             MASTER_BIT    = 12;
   localparam int             ENABLE_BIT    = 8;
   localparam int             POL_BIT       = 4;
   localparam int             TYPE_BIT      = 0;
   localparam logic [7:0]     INTERVAL_RST  = 8'h00;
   localparam logic           ENABLE_RST    = 1'b0;
   localparam logic           POL_RST       = 1'b0;
   localparam logic           TYPE_RST      = 1'b0;
   localparam int             STEP_NS       = 10000;
   localparam int             CLK_PERIOD_NS = 10;
   localparam int             STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;
   localparam logic [1:0]     RESP_OKAY     = 2'h0;
   localparam logic [1:0]     RESP_SLVERR   = 2'h2;
endpackage

/* core/irqoc_tick.sv */
// Purpose: Step generator that marks each 10 us of a running hold-off interval.
// Assumes: run and restart are synchronous to aclk.
// Notes:   restart realigns the step so a fresh interval gets whole steps.
`timescale 1ns/1ns
`default_nettype none
module irqoc_tick #(
   parameter int CYCLES = irqoc_pkg::STEP_CYCLES
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic restart,
   output wire logic tick
);
   localparam int W = $clog2(CYCLES);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } irqoc_tick_t;

   irqoc_tick_t s_ff;
   irqoc_tick_t nxt_s;

   always_comb begin
      nxt_s      = s_ff;
      nxt_s.tick = 1'b0;
      if (restart || !run) begin
         nxt_s.cnt = '0;
      end else if (s_ff.cnt == LAST) begin
         nxt_s.cnt  = '0;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt = s_ff.cnt + W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tick = s_ff.tick;
endmodule
`default_nettype wire

/* core/irqoc_top.sv */
// Purpose: Drives the single interrupt request pin from the combined sources.
// Assumes: AXI4-Lite register access; source inputs are already enable-gated.
// Notes:   soft_reset clears the configuration except polarity and buffer type.
//
// What this block does
// R1 - Top byte of the config register sets hold-off length in 10 us steps.
// R2 - Zero interval disables hold-off, clears its counter, releases pending interrupts.
// R3 - A new non-zero interval applies to every later interrupt.
// R4 - Power event source bypasses the hold-off entirely.
// R5 - Writing one to restart bit starts a fresh interval; bit self-clears.
// R6 - Read-only status bit is one while an interval withholds interrupts.
// R7 - Read-only master bit shows the combined line, ignoring enable and hold-off.
// R8 - With output enable clear the pin stays de-asserted; status is untouched.
// R9 - Polarity zero drives the pin active low, one active high.
// R10 - In open-drain mode polarity is ignored; the pin is active low.
// R11 - Buffer-type zero selects open-drain, one selects push-pull.
// R12 - Polarity and buffer type survive soft reset; the digital reset (aresetn) clears them.
// R13 - When an interval expires with the line still active, the pin asserts.
`timescale 1ns/1ns
`default_nettype none
module irqoc_top #(
   parameter int N_SRC = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             soft_reset,
   input  wire logic [N_SRC-1:0] src_active,
   input  wire logic             power_event_source,
   output wire logic             irq_pin_out,
   output wire logic             irq_pin_oe,
   input  wire logic [11:0]      s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output wire logic             s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output wire logic             s_axi_wready,
   output wire logic [1:0]       s_axi_bresp,
   output wire logic             s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [11:0]      s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output wire logic             s_axi_arready,
   output wire logic [31:0]      s_axi_rdata,
   output wire logic [1:0]       s_axi_rresp,
   output wire logic             s_axi_rvalid,
   input  wire logic             s_axi_rready
);
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        arready;
      logic        aw_held;
      logic        w_held;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [7:0]  interval;
      logic        enable;
      logic        pol;
      logic        ptype;
      logic [7:0]  cnt;
      logic        line;
      logic        norm_on;
      logic        deliver;
      logic        pin_out;
      logic        pin_oe;
   } irqoc_state_t;

   irqoc_state_t s_ff;
   irqoc_state_t nxt_s;
   logic         tick;
   logic         load;
   logic         wr_fire;
   logic         restart_req;
   logic         normal;
   logic         pin_on;

   irqoc_tick #(
      .CYCLES (irqoc_pkg::STEP_CYCLES)
   ) irqoc_tick_inst (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (s_ff.cnt != 8'h00),
      .restart (load),
      .tick    (tick)
   );

   always_comb begin
      nxt_s       = s_ff;
      load        = 1'b0;
      restart_req = 1'b0;
      normal      = |src_active;
      wr_fire     = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
      nxt_s.line  = normal || power_event_source;
      // Address and data are taken independently, in either order.
      if (s_axi_awvalid && s_ff.awready) begin
         nxt_s.awaddr  = s_axi_awaddr;
         nxt_s.aw_held = 1'b1;
         nxt_s.awready = 1'b0;
      end
      if (s_axi_wvalid && s_ff.wready) begin
         nxt_s.wdata  = s_axi_wdata;
         nxt_s.wstrb  = s_axi_wstrb;
         nxt_s.w_held = 1'b1;
         nxt_s.wready = 1'b0;
      end
      if (wr_fire) begin
         nxt_s.aw_held = 1'b0;
         nxt_s.w_held  = 1'b0;
         nxt_s.bvalid  = 1'b1;
         nxt_s.bresp   = irqoc_pkg::RESP_SLVERR;
         if (s_ff.awaddr[11:2] == irqoc_pkg::CFG_OFFSET[11:2]) begin
            nxt_s.bresp = irqoc_pkg::RESP_OKAY;
            if (s_ff.wstrb[3]) begin
               nxt_s.interval = s_ff.wdata[irqoc_pkg::INTERVAL_LSB +: 8];  // [R1]
            end
            if (s_ff.wstrb[1]) begin
               restart_req  = s_ff.wdata[irqoc_pkg::RESTART_BIT];
               nxt_s.enable = s_ff.wdata[irqoc_pkg::ENABLE_BIT];
            end
            if (s_ff.wstrb[0]) begin
               nxt_s.pol   = s_ff.wdata[irqoc_pkg::POL_BIT];
               nxt_s.ptype = s_ff.wdata[irqoc_pkg::TYPE_BIT];
            end
         end
      end
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid  = 1'b0;
         nxt_s.awready = 1'b1;
         nxt_s.wready  = 1'b1;
      end
      if (s_axi_arvalid && s_ff.arready) begin
         nxt_s.arready = 1'b0;
         nxt_s.rvalid  = 1'b1;
         nxt_s.rdata   = 32'h0000_0000;
         nxt_s.rresp   = irqoc_pkg::RESP_SLVERR;
         if (s_axi_araddr[11:2] == irqoc_pkg::CFG_OFFSET[11:2]) begin
            nxt_s.rresp = irqoc_pkg::RESP_OKAY;
            nxt_s.rdata[irqoc_pkg::INTERVAL_LSB +: 8] = s_ff.interval;
            nxt_s.rdata[irqoc_pkg::ACTIVE_BIT]        = s_ff.cnt != 8'h00;  // [R6]
            nxt_s.rdata[irqoc_pkg::MASTER_BIT]        = s_ff.line;          // [R7]
            nxt_s.rdata[irqoc_pkg::ENABLE_BIT]        = s_ff.enable;
            nxt_s.rdata[irqoc_pkg::POL_BIT]           = s_ff.pol;
            nxt_s.rdata[irqoc_pkg::TYPE_BIT]          = s_ff.ptype;
         end
      end
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid  = 1'b0;
         nxt_s.arready = 1'b1;
      end
      // Soft reset spares polarity and buffer type.
      if (soft_reset) begin
         nxt_s.interval = irqoc_pkg::INTERVAL_RST;  // [R12]
         nxt_s.enable   = irqoc_pkg::ENABLE_RST;
         restart_req    = 1'b0;
      end
      // Hold-off counter: loaded when delivered interrupts drop or on restart.
      if (nxt_s.interval == 8'h00) begin
         nxt_s.cnt = 8'h00;  // [R2]
      end else if (restart_req || (s_ff.norm_on && !normal)) begin
         nxt_s.cnt = nxt_s.interval;  // [R3] [R5]
         load      = 1'b1;
      end else if (tick && s_ff.cnt != 8'h00) begin
         nxt_s.cnt = s_ff.cnt - 8'h01;  // [R1]
      end
      nxt_s.norm_on = normal && (nxt_s.cnt == 8'h00);
      nxt_s.deliver = nxt_s.norm_on || power_event_source;  // [R4] [R13]
      pin_on        = nxt_s.enable && nxt_s.deliver;        // [R8]
      if (nxt_s.ptype) begin
         nxt_s.pin_oe  = 1'b1;                             // [R11]
         nxt_s.pin_out = nxt_s.pol ? pin_on : !pin_on;     // [R9]
      end else begin
         nxt_s.pin_oe  = pin_on;                           // [R10] [R11]
         nxt_s.pin_out = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff          <= '0;
         s_ff.awready  <= 1'b1;
         s_ff.wready   <= 1'b1;
         s_ff.arready  <= 1'b1;
         s_ff.interval <= irqoc_pkg::INTERVAL_RST;
         s_ff.enable   <= irqoc_pkg::ENABLE_RST;
         s_ff.pol      <= irqoc_pkg::POL_RST;
         s_ff.ptype    <= irqoc_pkg::TYPE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign irq_pin_out   = s_ff.pin_out;
   assign irq_pin_oe    = s_ff.pin_oe;
   assign s_axi_awready = s_ff.awready;
   assign s_axi_wready  = s_ff.wready;
   assign s_axi_bresp   = s_ff.bresp;
   assign s_axi_bvalid  = s_ff.bvalid;
   assign s_axi_arready = s_ff.arready;
   assign s_axi_rdata   = s_ff.rdata;
   assign s_axi_rresp   = s_ff.rresp;
   assign s_axi_rvalid  = s_ff.rvalid;

   // Pin asserted in its electrical sense, for the checks below.
   logic pin_asserted;
   assign pin_asserted = s_ff.ptype ? (s_ff.pin_out == s_ff.pol) : s_ff.pin_oe;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_r1_count;
      tick && s_ff.cnt != 8'h00 && !load && nxt_s.interval != 8'h00
         |=> s_ff.cnt == $past(s_ff.cnt) - 8'h01;
   endproperty
   a_r1_count: assert property (p_r1_count) else $error("hold-off count did not step"); // [R1]

   property p_r2_zero;
      s_ff.interval == 8'h00 && $past(aresetn)
         |-> s_ff.cnt == 8'h00 && s_ff.norm_on == (|$past(src_active));
   endproperty
   a_r2_zero: assert property (p_r2_zero) else $error("counter runs with zero interval"); // [R2]

   property p_r3_load;
      s_ff.norm_on && !(|src_active) && nxt_s.interval != 8'h00 && !restart_req
         |=> s_ff.cnt == $past(nxt_s.interval);
   endproperty
   a_r3_load: assert property (p_r3_load) else $error("interval not loaded on drop"); // [R3]

   property p_r4_bypass;
      power_event_source && nxt_s.enable |=> pin_asserted;
   endproperty
   a_r4_bypass: assert property (p_r4_bypass) else $error("power event held off"); // [R4]

   property p_r5_restart;
      restart_req && nxt_s.interval != 8'h00 |=> s_ff.cnt == $past(nxt_s.interval);
   endproperty
   a_r5_restart: assert property (p_r5_restart) else $error("restart did not reload"); // [R5]

   property p_r6_status;
      s_axi_arvalid && s_ff.arready && s_axi_araddr[11:2] == irqoc_pkg::CFG_OFFSET[11:2]
         |=> s_ff.rdata[irqoc_pkg::ACTIVE_BIT] == ($past(s_ff.cnt) != 8'h00)
             && s_ff.rdata[irqoc_pkg::MASTER_BIT] == $past(s_ff.line);
   endproperty
   a_r6_status: assert property (p_r6_status) else $error("status bits misread"); // [R6] [R7]

   property p_r8_disable;
      !s_ff.enable |-> !pin_asserted;
   endproperty
   a_r8_disable: assert property (p_r8_disable) else $error("pin asserted while disabled"); // [R8]

   property p_r9_pol;
      s_ff.ptype && s_ff.enable && s_ff.deliver |-> s_ff.pin_out == s_ff.pol;
   endproperty
   a_r9_pol: assert property (p_r9_pol) else $error("push-pull sense wrong"); // [R9]

   property p_r10_od;
      !s_ff.ptype |-> !s_ff.pin_out && (s_ff.pin_oe == (s_ff.enable && s_ff.deliver));
   endproperty
   a_r10_od: assert property (p_r10_od) else $error("open-drain pin misdriven"); // [R10] [R11]

   property p_r12_keep;
      soft_reset && !wr_fire |=> $stable(s_ff.pol) && $stable(s_ff.ptype) && !s_ff.enable;
   endproperty
   a_r12_keep: assert property (p_r12_keep) else $error("soft reset disturbed pin bits"); // [R12]

   property p_r13_expire;
      s_ff.cnt == 8'h01 && tick && (|src_active) && s_ff.enable && !soft_reset && !wr_fire
         |=> pin_asserted;
   endproperty
   a_r13_expire: assert property (p_r13_expire) else $error("pin not asserted at expiry"); // [R13]

   c_holdoff_run: cover property (s_ff.cnt != 8'h00 ##1 s_ff.cnt == 8'h00);
   c_pme_in_hold: cover property (s_ff.cnt != 8'h00 && power_event_source && s_ff.enable);
   c_restart:     cover property (restart_req && s_ff.cnt != 8'h00);
endmodule
`default_nettype wire

/* verification/irqoc_host.sv */
// Purpose: Host side of the interrupt pin, as seen by the host's input.
// Assumes: The board holds the pin high through a pull-up resistor.
// Notes:   Push-pull drives the pin all the time; open-drain only pulls low.
`timescale 1ns/1ns
`default_nettype none
module irqoc_host (
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output wire logic pin_wire
);
   // With no driver enabled the pull-up decides the level.
   assign pin_wire = pin_oe ? pin_out : 1'b1;
endmodule
`default_nettype wire

/* verification/irq_output_config_tb.sv */
// Purpose: Self-checking bench for the interrupt pin configuration block.
// Assumes: One hold-off step is irqoc_pkg::STEP_CYCLES clock cycles.
// Notes:   The pin is judged at the host's side of the wire.
`timescale 1ns/1ns
`default_nettype none
module irq_output_config_tb;
   localparam logic [11:0] CFG = irqoc_pkg::CFG_OFFSET;
   localparam int          MB  = 32'h1 << irqoc_pkg::MASTER_BIT;
   localparam int          HB  = 32'h1 << irqoc_pkg::ACTIVE_BIT;
   logic        aclk, aresetn, soft_reset, pwr, pin_out, pin_oe, pin_wire;
   logic [7:0]  src;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_v;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, b_v;
   int          miscompares, checked;

   irqoc_top #(.N_SRC(8)) irqoc_top_inst (.aclk(aclk), .aresetn(aresetn),
      .soft_reset(soft_reset), .src_active(src), .power_event_source(pwr),
      .irq_pin_out(pin_out), .irq_pin_oe(pin_oe), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   irqoc_host irqoc_host_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_wire(pin_wire));

   always #5 aclk = ~aclk;

   function automatic logic [31:0] cfg(input logic [7:0] iv, input logic en, pol, ty);
      cfg = {iv, 24'h0} | ({31'h0, en} << irqoc_pkg::ENABLE_BIT)
          | ({31'h0, pol} << irqoc_pkg::POL_BIT) | ({31'h0, ty} << irqoc_pkg::TYPE_BIT);
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            b_v = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd_v = rdata;
            b_v = rresp;
            rready <= 1'b0;
            break;
         end
      end
      check("rdata", rd_v, e);
      check("rresp", {30'h0, b_v}, {30'h0, er});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic pin(input logic e);
      check("pin", {31'h0, pin_wire}, {31'h0, e});
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      wrap_up;
   end

   initial begin
      aclk = 0; aresetn = 0; soft_reset = 0; pwr = 0; src = 8'h00;
      awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
      awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      miscompares = 0; checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(CFG, 32'h0, irqoc_pkg::RESP_OKAY);
      pin(1'b1);
      rdc(12'h058, 32'h0, irqoc_pkg::RESP_SLVERR);
      wr(12'h058, 32'hFFFFFFFF, 4'hF);
      check("bresp", {30'h0, b_v}, {30'h0, irqoc_pkg::RESP_SLVERR});
      $display("reset and map test done");
      for (int i = 0; i < 4; i++) begin
         wr(CFG, cfg(8'h00, 1'b1, i[1], i[0]), 4'hF);
         check("bresp", {30'h0, b_v}, {30'h0, irqoc_pkg::RESP_OKAY});
         src <= 8'h80;
         cyc(3);
         pin(i[0] ? i[1] : 1'b0);
         src <= 8'h00;
         cyc(3);
         pin(i[0] ? !i[1] : 1'b1);
      end
      $display("polarity and buffer test done");
      wr(CFG, cfg(8'h00, 1'b0, 1'b1, 1'b1), 4'hF);
      src <= 8'h01;
      cyc(3);
      pin(1'b0);
      rdc(CFG, cfg(8'h00, 1'b0, 1'b1, 1'b1) | MB, irqoc_pkg::RESP_OKAY);
      $display("enable test done");
      wr(CFG, cfg(8'h02, 1'b1, 1'b0, 1'b0), 4'hF);
      cyc(3);
      pin(1'b0);
      src <= 8'h00;
      cyc(3);
      pin(1'b1);
      rdc(CFG, cfg(8'h02, 1'b1, 1'b0, 1'b0) | HB, irqoc_pkg::RESP_OKAY);
      src <= 8'h04;
      cyc(990);
      pin(1'b1);
      pwr <= 1'b1;
      cyc(3);
      pin(1'b0);
      pwr <= 1'b0;
      cyc(3);
      pin(1'b1);
      cyc(1100);
      pin(1'b0);
      rdc(CFG, cfg(8'h02, 1'b1, 1'b0, 1'b0) | MB, irqoc_pkg::RESP_OKAY);
      $display("hold-off test done");
      src <= 8'h00;
      cyc(1500);
      wr(CFG, cfg(8'h02, 1'b1, 1'b0, 1'b0) | (32'h1 << irqoc_pkg::RESTART_BIT), 4'hF);
      src <= 8'h10;
      cyc(1500);
      pin(1'b1);
      rdc(CFG, cfg(8'h02, 1'b1, 1'b0, 1'b0) | HB | MB, irqoc_pkg::RESP_OKAY);
      wr(CFG, cfg(8'h00, 1'b1, 1'b0, 1'b0), 4'hF);
      cyc(3);
      pin(1'b0);
      rdc(CFG, cfg(8'h00, 1'b1, 1'b0, 1'b0) | MB, irqoc_pkg::RESP_OKAY);
      $display("restart and clear test done");
      wr(CFG, cfg(8'h05, 1'b1, 1'b1, 1'b1), 4'hF);
      soft_reset <= 1'b1;
      cyc(1);
      soft_reset <= 1'b0;
      src <= 8'h00;
      cyc(3);
      rdc(CFG, cfg(8'h00, 1'b0, 1'b1, 1'b1), irqoc_pkg::RESP_OKAY);
      pin(1'b0);
      wr(CFG, cfg(8'hAA, 1'b1, 1'b0, 1'b0), 4'h8);
      rdc(CFG, cfg(8'hAA, 1'b0, 1'b1, 1'b1), irqoc_pkg::RESP_OKAY);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      rdc(CFG, 32'h0, irqoc_pkg::RESP_OKAY);
      $display("reset retention test done");
      wrap_up;
   end
endmodule
`default_nettype wire
